// ==== core/rcr_top.sv ====
// receive control register bank for two line channels, with the control
// outputs it steers and the recovered-data launcher
// assumes the host serial interface hands over a decoded address and
// single-cycle read and write strobes on MCLK
`timescale 1ns/1ps
`default_nettype none

module rcr_top (
  // clock and reset
  input  wire logic                           MCLK,
  input  wire logic                           RESETN,
  // host register port
  input  wire logic [rcr_pkg::ADDR_W-1:0]     REG_ADDR,
  input  wire logic                           REG_WR,
  input  wire logic                           REG_RD,
  input  wire logic [rcr_pkg::DATA_W-1:0]     REG_WDATA,
  output logic      [rcr_pkg::DATA_W-1:0]     REG_RDATA,
  // channel status inputs
  input  wire logic [rcr_pkg::NUM_CH-1:0]     CH_E3_MODE,
  input  wire logic [rcr_pkg::NUM_CH-1:0]     CH_LOS,
  // recovered clock and raw data
  input  wire logic [rcr_pkg::NUM_CH-1:0]     RECOVERED_CLOCK,
  input  wire logic [rcr_pkg::NUM_CH-1:0]     RAW_POSITIVE_DATA,
  input  wire logic [rcr_pkg::NUM_CH-1:0]     RAW_NEGATIVE_DATA,
  // receiver control outputs
  output logic      [rcr_pkg::NUM_CH-1:0]     DIGITAL_LOS_ENABLE,
  output logic      [rcr_pkg::NUM_CH-1:0]     ANALOG_LOS_ENABLE,
  output logic      [rcr_pkg::NUM_CH-1:0]     MONITOR_MODE,
  output logic      [rcr_pkg::NUM_CH-1:0]     EQUALIZER_ENABLE,
  // recovered data outputs
  output logic      [rcr_pkg::NUM_CH-1:0]     RECOVERED_POSITIVE_DATA,
  output logic      [rcr_pkg::NUM_CH-1:0]     RECOVERED_NEGATIVE_DATA
);
  import rcr_pkg::*;

  logic [DATA_W-1:0] ctl_reg  [NUM_CH];
  logic [DATA_W-1:0] ctl_next [NUM_CH];
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  rcr_cfg_if cfg ();

  // ==========================================================================
  // address decode
  function automatic logic ch_hit(input logic [ADDR_W-1:0] addr, input int unsigned ch);
    logic [ADDR_W-1:0] base;
    base = (ch == 0) ? RCR_ADDR_CH0 : RCR_ADDR_CH1;
    return addr == base;
  endfunction : ch_hit

  // ==========================================================================
  // register bank
  always_comb begin
    rdata_next = RCR_RD_NONE;
    for (int c = 0; c < NUM_CH; c++) begin
      ctl_next[c] = ctl_reg[c];
      if (REG_WR && ch_hit(REG_ADDR, c)) begin
        // reserved bits never store, so they always read back zero
        ctl_next[c] = REG_WDATA & RCR_RW_MASK;
      end
      if (REG_RD && ch_hit(REG_ADDR, c)) begin
        rdata_next = ctl_reg[c];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctl_reg[c] <= RCR_RESET;
      end
      rdata_reg <= RCR_RD_NONE;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctl_reg[c] <= ctl_next[c];
      end
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

  // ==========================================================================
  // control outputs
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign DIGITAL_LOS_ENABLE[g] = ~(ctl_reg[g][BIT_DLOS_OFF] & ~CH_E3_MODE[g]);
    assign ANALOG_LOS_ENABLE[g]  = ~(ctl_reg[g][BIT_ALOS_OFF] & ~CH_E3_MODE[g]);
    assign MONITOR_MODE[g]       = ctl_reg[g][BIT_MONITOR];
    assign EQUALIZER_ENABLE[g]   = ctl_reg[g][BIT_EQ];
    assign cfg.edge_fall[g]      = ctl_reg[g][BIT_EDGE_SEL];
    assign cfg.mute_en[g]        = ctl_reg[g][BIT_MUTE];
  end
  assign cfg.los = CH_LOS;

  // ==========================================================================
  // recovered data path
  rcr_launch u_launch (
    .clk     (MCLK),
    .rst_n   (RESETN),
    .cfg     (cfg.lnc),
    .rclk    (RECOVERED_CLOCK),
    .pos_in  (RAW_POSITIVE_DATA),
    .neg_in  (RAW_NEGATIVE_DATA),
    .pos_out (RECOVERED_POSITIVE_DATA),
    .neg_out (RECOVERED_NEGATIVE_DATA)
  );

  // ==========================================================================
  // checks
  a_write_read_back: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1) ##1 (REG_RD && !REG_WR && REG_ADDR == RCR_ADDR_CH1)
      |=> REG_RDATA == ($past(REG_WDATA, 2) & RCR_RW_MASK))
    else $error("channel 1 register did not read back the written value");

  a_unmapped_reads_zero: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_RD && REG_ADDR != RCR_ADDR_CH0 && REG_ADDR != RCR_ADDR_CH1) |=> REG_RDATA == RCR_RD_NONE)
    else $error("unmapped read returned data");

  a_reserved_read_zero: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    REG_RDATA[BIT_RSV_HI:BIT_RSV_LO] == '0)
    else $error("reserved bits read nonzero");

  a_dlos_off_ds3: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0 && REG_WDATA[BIT_DLOS_OFF]) ##1 !CH_E3_MODE[0]
      |-> !DIGITAL_LOS_ENABLE[0])
    else $error("digital detector still enabled after disable write");

  a_alos_off_ds3: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1 && REG_WDATA[BIT_ALOS_OFF]) ##1 !CH_E3_MODE[1]
      |-> !ANALOG_LOS_ENABLE[1])
    else $error("analog detector still enabled after disable write");

  a_e3_ignores_off: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CH_E3_MODE[0] |-> DIGITAL_LOS_ENABLE[0] && ANALOG_LOS_ENABLE[0])
    else $error("detector disabled while in E3 mode");

  a_monitor_mode_set: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1) |=> MONITOR_MODE[1] == $past(REG_WDATA[BIT_MONITOR]))
    else $error("monitor mode does not follow the write");

  a_equalizer_set: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0) |=> EQUALIZER_ENABLE[0] == $past(REG_WDATA[BIT_EQ]))
    else $error("equalizer enable does not follow the write");

  a_write_read_ch0: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0) ##1 (REG_RD && !REG_WR && REG_ADDR == RCR_ADDR_CH0)
      |=> REG_RDATA == ($past(REG_WDATA, 2) & RCR_RW_MASK))
    else $error("channel 0 register did not read back the written value");

  a_idle_rdata_zero: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    !REG_RD |=> REG_RDATA == RCR_RD_NONE)
    else $error("read data stood longer than one cycle");

  a_stray_write_hold: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    !(REG_WR && (REG_ADDR == RCR_ADDR_CH0 || REG_ADDR == RCR_ADDR_CH1))
      |=> $stable(MONITOR_MODE) && $stable(EQUALIZER_ENABLE))
    else $error("control outputs changed without a mapped write");

  a_digital_off_ch1: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1 && REG_WDATA[BIT_DLOS_OFF]) ##1 !CH_E3_MODE[1]
      |-> !DIGITAL_LOS_ENABLE[1])
    else $error("channel 1 digital detector still enabled after disable write");

  a_digital_on_ch0: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0 && !REG_WDATA[BIT_DLOS_OFF]) |=> DIGITAL_LOS_ENABLE[0])
    else $error("channel 0 digital detector off after enable write");

  a_analog_off_ch0: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0 && REG_WDATA[BIT_ALOS_OFF]) ##1 !CH_E3_MODE[0]
      |-> !ANALOG_LOS_ENABLE[0])
    else $error("channel 0 analog detector still enabled after disable write");

  a_analog_on_ch1: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1 && !REG_WDATA[BIT_ALOS_OFF]) |=> ANALOG_LOS_ENABLE[1])
    else $error("channel 1 analog detector off after enable write");

  a_e3_ignores_ch1: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CH_E3_MODE[1] |-> DIGITAL_LOS_ENABLE[1] && ANALOG_LOS_ENABLE[1])
    else $error("channel 1 detector disabled while in E3 mode");

  a_monitor_mode_ch0: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH0) |=> MONITOR_MODE[0] == $past(REG_WDATA[BIT_MONITOR]))
    else $error("channel 0 monitor mode does not follow the write");

  a_equalizer_ch1: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    (REG_WR && REG_ADDR == RCR_ADDR_CH1) |=> EQUALIZER_ENABLE[1] == $past(REG_WDATA[BIT_EQ]))
    else $error("channel 1 equalizer enable does not follow the write");

endmodule : rcr_top
`default_nettype wire

// ==== pkg/rcr_pkg.sv ====
// constants of the per-channel receive control register bank
// assumes the host serial port is already decoded into address and strobes
package rcr_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // register map
  localparam logic [ADDR_W-1:0] RCR_ADDR_CH0 = 8'h05;
  localparam logic [ADDR_W-1:0] RCR_ADDR_CH1 = 8'h0D;
  localparam logic [DATA_W-1:0] RCR_RESET    = 8'h00;
  // bits 7:6 are read-only zero
  localparam logic [DATA_W-1:0] RCR_RW_MASK  = 8'h3F;
  localparam logic [DATA_W-1:0] RCR_RD_NONE  = 8'h00;

  // ==========================================================================
  // field positions
  localparam int unsigned BIT_DLOS_OFF = 5;
  localparam int unsigned BIT_ALOS_OFF = 4;
  localparam int unsigned BIT_EDGE_SEL = 3;
  localparam int unsigned BIT_MUTE     = 2;
  localparam int unsigned BIT_MONITOR  = 1;
  localparam int unsigned BIT_EQ       = 0;
  localparam int unsigned BIT_RSV_LO   = 6;
  localparam int unsigned BIT_RSV_HI   = 7;

endpackage : rcr_pkg

// ==== pkg/rcr_cfg_if.sv ====
// configuration from the register bank and loss-of-signal state from CH_LOS, handed to the
// recovered-data launcher; assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface rcr_cfg_if;
  import rcr_pkg::*;
  logic [NUM_CH-1:0] edge_fall;
  logic [NUM_CH-1:0] mute_en;
  logic [NUM_CH-1:0] los;
  modport ctl (output edge_fall, output mute_en, output los);
  modport lnc (input edge_fall, input mute_en, input los);
endinterface : rcr_cfg_if
`default_nettype wire

// ==== core/rcr_launch.sv ====
// recovered data launcher: re-times positive/negative data on the selected
// recovered-clock edge and mutes it on loss of signal
// assumes recovered clock and data are synchronous samples on the system clock
`timescale 1ns/1ps
`default_nettype none
module rcr_launch (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // configuration
  rcr_cfg_if.lnc                          cfg,
  // recovered clock and data
  input  wire logic [rcr_pkg::NUM_CH-1:0] rclk,
  input  wire logic [rcr_pkg::NUM_CH-1:0] pos_in,
  input  wire logic [rcr_pkg::NUM_CH-1:0] neg_in,
  output logic      [rcr_pkg::NUM_CH-1:0] pos_out,
  output logic      [rcr_pkg::NUM_CH-1:0] neg_out
);
  import rcr_pkg::*;

  logic [NUM_CH-1:0] prev_reg;
  logic [NUM_CH-1:0] pos_reg;
  logic [NUM_CH-1:0] neg_reg;
  logic [NUM_CH-1:0] pos_next;
  logic [NUM_CH-1:0] neg_next;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;

  // ==========================================================================
  // edge select and mute
  always_comb begin
    rise     = rclk & ~prev_reg;
    fall     = ~rclk & prev_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    for (int c = 0; c < NUM_CH; c++) begin
      if (cfg.mute_en[c] && cfg.los[c]) begin
        pos_next[c] = 1'b0;
        neg_next[c] = 1'b0;
      end else if (cfg.edge_fall[c] ? fall[c] : rise[c]) begin
        pos_next[c] = pos_in[c];
        neg_next[c] = neg_in[c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
      pos_reg  <= '0;
      neg_reg  <= '0;
    end else begin
      prev_reg <= rclk;
      pos_reg  <= pos_next;
      neg_reg  <= neg_next;
    end
  end

  assign pos_out = pos_reg;
  assign neg_out = neg_reg;

  // ==========================================================================
  // checks
  a_rise_launch_data: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!cfg.edge_fall[0] && rclk[0] && !prev_reg[0] && !(cfg.mute_en[0] && cfg.los[0]))
      |=> (pos_out[0] == $past(pos_in[0])) && (neg_out[0] == $past(neg_in[0])))
    else $error("data not launched on rising recovered clock");

  a_fall_launch_data: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg.edge_fall[1] && !rclk[1] && prev_reg[1] && !(cfg.mute_en[1] && cfg.los[1]))
      |=> (pos_out[1] == $past(pos_in[1])) && (neg_out[1] == $past(neg_in[1])))
    else $error("data not launched on falling recovered clock");

  a_wrong_edge_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg.edge_fall[0] && rclk[0] && !prev_reg[0] && !(cfg.mute_en[0] && cfg.los[0]))
      |=> $stable(pos_out[0]) && $stable(neg_out[0]))
    else $error("data launched on the unselected edge");

  a_mute_forces_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfg.mute_en[0] && cfg.los[0]) [*2] |-> !pos_out[0] && !neg_out[0])
    else $error("recovered data not muted during loss of signal");

endmodule : rcr_launch
`default_nettype wire

// ==== tb/test_rcr_top.sv ====
// self-checking bench for the receive control register bank: register access,
// control outputs and recovered-data launch; drives every port itself
`timescale 1ns/1ps
`default_nettype none
module test_rcr_top;
  import rcr_pkg::*;

  // ==========================================================================
  // signals
  logic              MCLK = 1'b0;
  logic              RESETN;
  logic [ADDR_W-1:0] REG_ADDR;
  logic              REG_WR;
  logic              REG_RD;
  logic [DATA_W-1:0] REG_WDATA;
  logic [DATA_W-1:0] REG_RDATA;
  logic [NUM_CH-1:0] CH_E3_MODE;
  logic [NUM_CH-1:0] CH_LOS;
  logic [NUM_CH-1:0] RECOVERED_CLOCK;
  logic [NUM_CH-1:0] RAW_POSITIVE_DATA;
  logic [NUM_CH-1:0] RAW_NEGATIVE_DATA;
  logic [NUM_CH-1:0] DIGITAL_LOS_ENABLE;
  logic [NUM_CH-1:0] ANALOG_LOS_ENABLE;
  logic [NUM_CH-1:0] MONITOR_MODE;
  logic [NUM_CH-1:0] EQUALIZER_ENABLE;
  logic [NUM_CH-1:0] RECOVERED_POSITIVE_DATA;
  logic [NUM_CH-1:0] RECOVERED_NEGATIVE_DATA;
  logic [7:0]        w;
  int                miscompares = 0;
  int                total_checks = 0;

  always #12.5 MCLK = ~MCLK;

  rcr_top dut_u (.MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CH_E3_MODE(CH_E3_MODE),
    .CH_LOS(CH_LOS), .RECOVERED_CLOCK(RECOVERED_CLOCK), .RAW_POSITIVE_DATA(RAW_POSITIVE_DATA),
    .RAW_NEGATIVE_DATA(RAW_NEGATIVE_DATA), .DIGITAL_LOS_ENABLE(DIGITAL_LOS_ENABLE),
    .ANALOG_LOS_ENABLE(ANALOG_LOS_ENABLE), .MONITOR_MODE(MONITOR_MODE),
    .EQUALIZER_ENABLE(EQUALIZER_ENABLE), .RECOVERED_POSITIVE_DATA(RECOVERED_POSITIVE_DATA),
    .RECOVERED_NEGATIVE_DATA(RECOVERED_NEGATIVE_DATA));

  // ==========================================================================
  // tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    #1;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(posedge MCLK);
    #1;
    REG_WR = 1'b0;
  endtask : wr

  // write, then read the same address in the very next cycle
  task wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge MCLK);
    #1;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(posedge MCLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b1;
    @(posedge MCLK);
    #1;
    REG_RD = 1'b0;
    chk(REG_RDATA, exp);
  endtask : wr_rd

  // read data stands only in the cycle after the strobe edge
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    #1;
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(posedge MCLK);
    #1;
    REG_RD = 1'b0;
    chk(REG_RDATA, exp);
  endtask : rd_chk

  task ctl(input logic [1:0] dl, input logic [1:0] al, input logic [1:0] mo,
           input logic [1:0] eq);
    chk({6'h00, DIGITAL_LOS_ENABLE}, {6'h00, dl});
    chk({6'h00, ANALOG_LOS_ENABLE}, {6'h00, al});
    chk({6'h00, MONITOR_MODE}, {6'h00, mo});
    chk({6'h00, EQUALIZER_ENABLE}, {6'h00, eq});
  endtask : ctl

  // one recovered-clock sample, outputs checked once the launch latency is over
  task step(input logic [1:0] rc, input logic [1:0] p, input logic [1:0] n,
            input logic [1:0] los, input logic [1:0] ep, input logic [1:0] en);
    @(posedge MCLK);
    #1;
    RECOVERED_CLOCK   = rc;
    RAW_POSITIVE_DATA = p;
    RAW_NEGATIVE_DATA = n;
    CH_LOS            = los;
    @(posedge MCLK);
    #1;
    chk({6'h00, RECOVERED_POSITIVE_DATA}, {6'h00, ep});
    chk({6'h00, RECOVERED_NEGATIVE_DATA}, {6'h00, en});
  endtask : step

  task end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // watchdog at 800 cycles: tests need fewer than a hundred cycles
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end

  // ==========================================================================
  // tests
  initial begin
    RESETN = 1'b0;
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 8'h00;
    CH_E3_MODE = 2'b00;
    CH_LOS = 2'b00;
    RECOVERED_CLOCK = 2'b00;
    RAW_POSITIVE_DATA = 2'b00;
    RAW_NEGATIVE_DATA = 2'b00;
    repeat (2) @(posedge MCLK);
    #1;
    RESETN = 1'b1;
    ctl(2'b11, 2'b11, 2'b00, 2'b00);
    rd_chk(RCR_ADDR_CH0, RCR_RESET);
    rd_chk(RCR_ADDR_CH1, RCR_RESET);
    // upper two bits are never stored
    wr_rd(RCR_ADDR_CH0, 8'hFF, 8'h3F);
    rd_chk(RCR_ADDR_CH1, 8'h00);
    wr(8'h06, 8'h15);
    rd_chk(8'h06, RCR_RD_NONE);
    rd_chk(RCR_ADDR_CH0, 8'h3F);
    rd_chk(RCR_ADDR_CH1, 8'h00);
    wr(RCR_ADDR_CH0, 8'h00);
    // each field alone on channel 1, read back in the next cycle
    for (int b = 0; b < 6; b++) begin
      w = 8'h01 << b;
      wr_rd(RCR_ADDR_CH1, w, w);
      ctl({~w[5], 1'b1}, {~w[4], 1'b1}, {w[1], 1'b0}, {w[0], 1'b0});
    end
    // detector-off bits only count outside E3
    wr(RCR_ADDR_CH0, 8'h30);
    wr(RCR_ADDR_CH1, 8'h30);
    for (int e = 0; e < 4; e++) begin
      @(posedge MCLK);
      #1;
      CH_E3_MODE = e[1:0];
      #1;
      ctl(e[1:0], e[1:0], 2'b00, 2'b00);
    end
    CH_E3_MODE = 2'b00;
    wr(RCR_ADDR_CH0, 8'h00);
    wr(RCR_ADDR_CH1, 8'h08);
    // channel 0 launches on rising, channel 1 on falling recovered clock
    step(2'b11, 2'b11, 2'b00, 2'b00, 2'b01, 2'b00);
    step(2'b00, 2'b00, 2'b11, 2'b00, 2'b01, 2'b10);
    step(2'b11, 2'b10, 2'b01, 2'b00, 2'b00, 2'b11);
    // mute on channel 0 only; channel 1 has no mute and keeps launching
    wr(RCR_ADDR_CH0, 8'h04);
    step(2'b11, 2'b11, 2'b00, 2'b01, 2'b00, 2'b10);
    step(2'b00, 2'b11, 2'b00, 2'b11, 2'b10, 2'b00);
    step(2'b11, 2'b11, 2'b00, 2'b00, 2'b11, 2'b00);
    // edges swapped: channel 0 on falling, channel 1 on rising
    wr(RCR_ADDR_CH0, 8'h08);
    wr(RCR_ADDR_CH1, 8'h00);
    step(2'b00, 2'b00, 2'b11, 2'b00, 2'b10, 2'b01);
    step(2'b11, 2'b01, 2'b10, 2'b00, 2'b00, 2'b11);
    end_of_test();
  end
endmodule : test_rcr_top
`default_nettype wire
